// >>> common/uvd_pkg.sv
// Shared constants of the vendor test command decoder
package uvd_pkg;
    localparam int CLK_KHZ = 10000;
    localparam int POLL_MS = 20;
    localparam int POLL_CYC = POLL_MS * CLK_KHZ;
    localparam int HRST_MS = 10;
    localparam int HRST_CYC = HRST_MS * CLK_KHZ;
    localparam logic [7:0] SIG_BYTE = 8'h4D;
    localparam logic [7:0] ADDR_SIG0 = 8'h00;
    localparam logic [7:0] ADDR_SIG1 = 8'h01;
    localparam logic [7:0] ADDR_DESIG = 8'h04;
    localparam logic [7:0] DESIG_RST = 8'h24;
    localparam logic [7:0] SUB_CFG = 8'h26;
    localparam logic [7:0] SUB_PIN = 8'h27;
    localparam logic [7:0] SRC_CFG_MEM = 8'h02;
    localparam logic [31:0] CFG_MAX_LEN = 32'h0000_00FF;
    localparam logic [4:0] CBW_LEN_LO = 5'h08;
    localparam logic [4:0] CBW_LEN_HI = 5'h0B;
    localparam logic [4:0] CBW_FLAGS = 5'h0C;
    localparam logic [4:0] CBW_CB_LO = 5'h0F;
    localparam logic [4:0] CBW_CB_HI = 5'h1E;
    localparam int DIR_BIT = 7;
    localparam logic [2:0] PIN_LOAD_BYTES = 3'h7;
    localparam logic [3:0] PIN_READ_BYTES = 4'h8;
endpackage

// >>> rtl/uvd_cmd_decoder.sv
// Power-up mode selection, bus-power polling and vendor command decoding
`timescale 1ns/100ps

module uvd_cmd_decoder #(
    parameter int POLL_CYCLES = uvd_pkg::POLL_CYC,
    parameter int HRST_CYCLES = uvd_pkg::HRST_CYC,
    parameter logic [7:0] DESIG_DEFAULT = uvd_pkg::DESIG_RST
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic chip_rst_n,
    input wire logic bus_power_valid_in,
    input wire logic hs_handshake_ok,
    output logic dplus_pullup_en,
    output logic usb_high_speed,
    output logic usb_enable,
    output logic ata_active,
    output logic mode_normal,
    output logic mode_board_test,
    output logic cfg_rd_req,
    output logic [7:0] cfg_rd_addr,
    input wire logic cfg_rd_done,
    input wire logic cfg_rd_nak,
    input wire logic [7:0] cfg_rd_data,
    input wire logic cbw_valid,
    input wire logic cbw_first,
    input wire logic [7:0] cbw_byte,
    input wire logic data_valid,
    input wire logic [7:0] data_byte,
    output logic cmd_cfg_load,
    output logic cmd_cfg_read,
    output logic cmd_pass,
    output logic cmd_fail,
    output logic cmd_ok,
    output logic [31:0] xfer_len,
    output logic rd_valid,
    output logic [7:0] rd_byte,
    output logic pin_test_mode,
    input wire logic [2:0] func_reg_sel,
    input wire logic [1:0] func_cs_n,
    input wire logic func_drive_reset_n,
    input wire logic func_wr_n,
    input wire logic func_rd_n,
    input wire logic func_dmack_n,
    input wire logic [15:0] func_data_out,
    input wire logic func_data_oe,
    input wire logic intrq_in,
    input wire logic iordy_in,
    input wire logic dmarq_in,
    input wire logic ata_en_in,
    input wire logic [15:0] ata_data_lines_in,
    output logic [2:0] ata_reg_select,
    output logic [1:0] ata_cs_n,
    output logic drive_reset_n,
    output logic ata_write_strobe_n,
    output logic ata_read_strobe_n,
    output logic ata_dma_ack_n,
    output logic [15:0] ata_data_lines_out,
    output logic ata_data_lines_oe
);
    typedef enum logic [2:0] {ST_SIG0, ST_SIG1, ST_DESIG, ST_NORMAL, ST_TEST} uvd_boot_e;

    function automatic logic [7:0] byte_at(input logic [127:0] v, input int n);
        byte_at = v[8*n +: 8];
    endfunction

    // Pins: two flops before use
    logic [21:0] pin_s1_ff, pin_s2_ff;
    always_ff @(posedge clk) begin
        pin_s1_ff <= {chip_rst_n, bus_power_valid_in, intrq_in, iordy_in, dmarq_in, ata_en_in, ata_data_lines_in};
        pin_s2_ff <= pin_s1_ff;
    end
    wire rst_pin_n = pin_s2_ff[21];
    wire vbus_s = pin_s2_ff[20];
    wire [15:0] dd_s = pin_s2_ff[15:0];

    logic [31:0] hrst_cnt_ff;
    logic hard_rst_ff;
    always_ff @(posedge clk) begin
        if (sys_rst || rst_pin_n) begin
            hrst_cnt_ff <= 32'h0000_0000;
            hard_rst_ff <= 1'b0;
        end else if (hrst_cnt_ff == 32'(HRST_CYCLES - 1)) begin
            hard_rst_ff <= 1'b1;
        end else begin
            hrst_cnt_ff <= hrst_cnt_ff + 32'h0000_0001;
        end
    end
    wire rst_all = sys_rst | hard_rst_ff;

    // Poll at start-up, then every interval
    logic [31:0] poll_cnt_ff;
    wire poll_tick = (poll_cnt_ff == 32'h0000_0000);
    always_ff @(posedge clk) begin
        if (rst_all) begin
            poll_cnt_ff <= 32'h0000_0000;
            dplus_pullup_en <= 1'b0;
        end else begin
            poll_cnt_ff <= poll_tick ? 32'(POLL_CYCLES - 1) : poll_cnt_ff - 32'h0000_0001;
            if (poll_tick) dplus_pullup_en <= vbus_s;
        end
    end

    // Boot sequence over the memory port
    uvd_boot_e st_ff, nxt_st;
    logic [7:0] desig_ff;
    wire sig_ok = (cfg_rd_data == uvd_pkg::SIG_BYTE);
    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            ST_SIG0: if (cfg_rd_nak || (cfg_rd_done && !sig_ok)) nxt_st = ST_TEST;
                     else if (cfg_rd_done) nxt_st = ST_SIG1;
            ST_SIG1: if (cfg_rd_nak || (cfg_rd_done && !sig_ok)) nxt_st = ST_TEST;
                     else if (cfg_rd_done) nxt_st = ST_DESIG;
            ST_DESIG: if (cfg_rd_nak) nxt_st = ST_TEST;
                      else if (cfg_rd_done) nxt_st = ST_NORMAL;
            ST_NORMAL: nxt_st = ST_NORMAL;
            ST_TEST: nxt_st = ST_TEST;
            default: nxt_st = ST_TEST;
        endcase
    end
    wire booting = (st_ff == ST_SIG0) || (st_ff == ST_SIG1) || (st_ff == ST_DESIG);
    always_ff @(posedge clk) begin
        if (rst_all) begin
            st_ff <= ST_SIG0;
            desig_ff <= DESIG_DEFAULT;
            cfg_rd_req <= 1'b0;
            cfg_rd_addr <= uvd_pkg::ADDR_SIG0;
        end else begin
            st_ff <= nxt_st;
            if (st_ff == ST_DESIG && cfg_rd_done) desig_ff <= cfg_rd_data;
            cfg_rd_req <= (nxt_st == ST_SIG0) || (nxt_st == ST_SIG1) || (nxt_st == ST_DESIG);
            cfg_rd_addr <= (nxt_st == ST_SIG1) ? uvd_pkg::ADDR_SIG1 :
                           (nxt_st == ST_DESIG) ? uvd_pkg::ADDR_DESIG : uvd_pkg::ADDR_SIG0;
        end
    end

    // High speed only after handshake, else full speed
    always_ff @(posedge clk) begin
        if (rst_all) begin
            usb_high_speed <= 1'b0;
            usb_enable <= 1'b0;
            ata_active <= 1'b0;
            mode_normal <= 1'b0;
            mode_board_test <= 1'b0;
        end else begin
            usb_high_speed <= hs_handshake_ok;
            // Enumerate in both modes, ATA only in normal
            usb_enable <= !booting;
            ata_active <= (st_ff == ST_NORMAL) && !pin_test_mode;
            mode_normal <= (st_ff == ST_NORMAL);
            mode_board_test <= (st_ff == ST_TEST);
        end
    end

    // Wrapper capture, byte index from first-byte marker
    logic [4:0] idx_ff;
    logic [127:0] cb_ff;
    logic dir_in_ff, go_ff;
    wire [4:0] idx = cbw_first ? 5'h00 : idx_ff;
    always_ff @(posedge clk) begin
        if (rst_all) begin
            idx_ff <= 5'h00;
            cb_ff <= '0;
            xfer_len <= 32'h0000_0000;
            dir_in_ff <= 1'b0;
            go_ff <= 1'b0;
        end else begin
            go_ff <= cbw_valid && (idx == uvd_pkg::CBW_CB_HI);
            if (cbw_valid) begin
                idx_ff <= idx + 5'h01;
                if (idx >= uvd_pkg::CBW_LEN_LO && idx <= uvd_pkg::CBW_LEN_HI)
                    xfer_len[8*(idx - uvd_pkg::CBW_LEN_LO) +: 8] <= cbw_byte;
                if (idx == uvd_pkg::CBW_FLAGS) dir_in_ff <= cbw_byte[uvd_pkg::DIR_BIT];
                if (idx >= uvd_pkg::CBW_CB_LO && idx <= uvd_pkg::CBW_CB_HI)
                    cb_ff[8*(idx - uvd_pkg::CBW_CB_LO) +: 8] <= cbw_byte;
            end
        end
    end

    // Decode of the captured block
    wire is_vendor = (byte_at(cb_ff, 0) == desig_ff);
    wire sub_cfg = (byte_at(cb_ff, 1) == uvd_pkg::SUB_CFG);
    wire sub_pin = (byte_at(cb_ff, 1) == uvd_pkg::SUB_PIN);
    // Fixed fields of the configuration block
    wire cfg_fields_ok = (byte_at(cb_ff, 2) == 8'h00) && (byte_at(cb_ff, 3) == uvd_pkg::SRC_CFG_MEM) &&
                         (cb_ff[47:32] == 16'h0000);
    wire cfg_len_ok = (xfer_len <= uvd_pkg::CFG_MAX_LEN);
    // Pin-test block has only zeros past byte 1
    wire pin_fields_ok = (cb_ff[127:16] == '0);
    wire cfg_good = sub_cfg && cfg_fields_ok && cfg_len_ok;
    wire pin_good = sub_pin && pin_fields_ok;
    wire dec_fire = go_ff && is_vendor;

    logic [2:0] pl_cnt_ff;
    logic [55:0] pl_ff;
    logic [63:0] snap_ff;
    logic [3:0] rd_cnt_ff;
    wire pin_load_go = dec_fire && pin_good && !dir_in_ff;
    wire pin_read_go = dec_fire && pin_good && dir_in_ff;
    wire pl_last = data_valid && (pl_cnt_ff == 3'h1);
    wire [7:0] snap_b0 = {drive_reset_n, vbus_s, 5'h00, pin_s2_ff[19]};
    wire [7:0] snap_b1 = {ata_data_lines_oe, 1'b0, pin_s2_ff[16], pin_s2_ff[17], pin_s2_ff[18], 3'h0};

    always_ff @(posedge clk) begin
        if (rst_all) begin
            cmd_cfg_load <= 1'b0;
            cmd_cfg_read <= 1'b0;
            cmd_pass <= 1'b0;
            cmd_fail <= 1'b0;
            cmd_ok <= 1'b0;
            pl_cnt_ff <= 3'h0;
            pl_ff <= '0;
            pin_test_mode <= 1'b0;
            snap_ff <= '0;
            rd_cnt_ff <= 4'h0;
            rd_valid <= 1'b0;
            rd_byte <= 8'h00;
        end else begin
            cmd_cfg_load <= dec_fire && cfg_good && !dir_in_ff;
            cmd_cfg_read <= dec_fire && cfg_good && dir_in_ff;
            cmd_pass <= go_ff && !is_vendor;
            cmd_fail <= dec_fire && !cfg_good && !pin_good;
            cmd_ok <= (pl_last && pl_cnt_ff != 3'h0) || pin_read_go;
            // Seven load bytes, extra bytes dropped
            if (pin_load_go) begin
                pl_cnt_ff <= uvd_pkg::PIN_LOAD_BYTES;
            end else if (data_valid && pl_cnt_ff != 3'h0) begin
                pl_cnt_ff <= pl_cnt_ff - 3'h1;
                pl_ff <= {data_byte, pl_ff[55:8]};
            end
            if (pl_last) pin_test_mode <= 1'b1;
            // Eight-byte snapshot, shifted out low byte first
            if (pin_read_go) begin
                snap_ff <= {32'h0000_0000, dd_s, snap_b1, snap_b0};
                rd_cnt_ff <= uvd_pkg::PIN_READ_BYTES;
            end else if (rd_cnt_ff != 4'h0) begin
                snap_ff <= {8'h00, snap_ff[63:8]};
                rd_cnt_ff <= rd_cnt_ff - 4'h1;
            end
            rd_valid <= (rd_cnt_ff != 4'h0) && !pin_read_go;
            rd_byte <= snap_ff[7:0];
        end
    end

    // Pin drivers; test mode before a load keeps ATA released
    wire [7:0] pl_b0 = pl_ff[7:0];
    wire [7:0] pl_b1 = pl_ff[15:8];
    wire func_on = (st_ff == ST_NORMAL);
    always_ff @(posedge clk) begin
        if (rst_all) begin
            ata_reg_select <= 3'h0;
            ata_cs_n <= 2'h3;
            drive_reset_n <= 1'b0;
            ata_write_strobe_n <= 1'b1;
            ata_read_strobe_n <= 1'b1;
            ata_dma_ack_n <= 1'b1;
            ata_data_lines_out <= 16'h0000;
            ata_data_lines_oe <= 1'b0;
        end else if (pin_test_mode) begin
            ata_reg_select <= pl_b0[3:1];
            ata_cs_n <= pl_b0[5:4];
            drive_reset_n <= pl_b0[7];
            ata_data_lines_out <= pl_ff[31:16];
            ata_write_strobe_n <= pl_b1[0];
            ata_read_strobe_n <= pl_b1[1];
            ata_dma_ack_n <= pl_b1[2];
            ata_data_lines_oe <= pl_b1[7];
        end else if (func_on) begin
            ata_reg_select <= func_reg_sel;
            ata_cs_n <= func_cs_n;
            drive_reset_n <= func_drive_reset_n;
            ata_write_strobe_n <= func_wr_n;
            ata_read_strobe_n <= func_rd_n;
            ata_dma_ack_n <= func_dmack_n;
            ata_data_lines_out <= func_data_out;
            ata_data_lines_oe <= func_data_oe;
        end else begin
            ata_data_lines_oe <= 1'b0;
        end
    end

    // Hard reset drops by register, so checks resume one edge after it
    logic rst_dly_ff;
    always_ff @(posedge clk) begin
        rst_dly_ff <= rst_all;
    end

    default clocking cb_clk @(posedge clk); endclocking
    default disable iff (rst_all || rst_dly_ff);

    property p_poll_hold;
        !poll_tick |=> $stable(dplus_pullup_en);
    endproperty
    a_poll_hold: assert property (p_poll_hold) else $error("pull-up changed between polls");
    property p_pullup;
        poll_tick |=> dplus_pullup_en == $past(vbus_s);
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up not following bus power");
    property p_hard_rst;
        @(posedge clk) disable iff (sys_rst) hard_rst_ff |=> !pin_test_mode && st_ff == ST_SIG0;
    endproperty
    a_hard_rst: assert property (p_hard_rst) else $error("hard reset did not clear device");
    property p_sig;
        st_ff == ST_SIG1 && cfg_rd_done && sig_ok |=> st_ff == ST_DESIG ##0 cfg_rd_addr == uvd_pkg::ADDR_DESIG;
    endproperty
    a_sig: assert property (p_sig) else $error("good signature not followed");
    property p_fallback;
        booting && cfg_rd_nak |=> st_ff == ST_TEST ##1 mode_board_test;
    endproperty
    a_fallback: assert property (p_fallback) else $error("no fallback to test mode");
    property p_test_ata;
        mode_board_test && !pin_test_mode |-> !ata_active && !ata_data_lines_oe;
    endproperty
    a_test_ata: assert property (p_test_ata) else $error("ATA active in test mode");
    property p_len;
        dec_fire && sub_cfg && xfer_len > uvd_pkg::CFG_MAX_LEN |=> cmd_fail && !cmd_cfg_load && !cmd_cfg_read;
    endproperty
    a_len: assert property (p_len) else $error("oversize transfer accepted");
    property p_sticky;
        pin_test_mode |=> pin_test_mode;
    endproperty
    a_sticky: assert property (p_sticky) else $error("pin-test mode left");
    property p_drive;
        pin_test_mode ##1 pin_test_mode |-> ata_data_lines_oe == $past(pl_ff[15]) && drive_reset_n == $past(pl_ff[7]);
    endproperty
    a_drive: assert property (p_drive) else $error("pins not driven from load");
    property p_read8;
        pin_read_go |=> ##1 rd_valid [*8] ##1 !rd_valid;
    endproperty
    a_read8: assert property (p_read8) else $error("pin read not eight bytes");
    property p_bad_sub;
        dec_fire && !sub_cfg && !sub_pin |=> cmd_fail;
    endproperty
    a_bad_sub: assert property (p_bad_sub) else $error("bad subcommand not failed");

    c_normal: cover property (st_ff == ST_DESIG ##1 st_ff == ST_NORMAL);
    c_cfg_read: cover property (cmd_cfg_read);
    c_pin_test: cover property (!pin_test_mode ##1 pin_test_mode);
    c_pin_read: cover property (rd_valid [*8]);
endmodule

// >>> testbench/test_usb_vendor_test_command_decoder.sv
// Self-checking bench of the vendor test command decoder
`timescale 1ns/100ps
module test_usb_vendor_test_command_decoder;
    localparam logic [7:0] DESIG = 8'h5A;
    logic clk = 1'b0;
    logic sys_rst, chip_rst_n, bus_power_valid_in, hs_handshake_ok, clr;
    logic cfg_rd_req, cfg_rd_done, cfg_rd_nak, cbw_valid, cbw_first, data_valid;
    logic [7:0] cfg_rd_addr, cfg_rd_data, cbw_byte, data_byte, rd_byte;
    logic dplus_pullup_en, usb_high_speed, usb_enable, ata_active, mode_normal, mode_board_test;
    logic cmd_cfg_load, cmd_cfg_read, cmd_pass, cmd_fail, cmd_ok, rd_valid, pin_test_mode;
    logic [31:0] xfer_len;
    logic [2:0] func_reg_sel, ata_reg_select;
    logic [1:0] func_cs_n, ata_cs_n, mem_mode;
    logic func_drive_reset_n, func_wr_n, func_rd_n, func_dmack_n, func_data_oe;
    logic intrq_in, iordy_in, dmarq_in, ata_en_in, drive_reset_n, ata_write_strobe_n;
    logic ata_read_strobe_n, ata_dma_ack_n, ata_data_lines_oe;
    logic [15:0] func_data_out, ata_data_lines_in, ata_data_lines_out;
    logic [3:0] mem_dly;
    logic [7:0] cb [16];
    logic [7:0] pin [7];
    logic [7:0] rdq [$];
    logic [4:0] mask_ff = 5'h00;
    int err_count = 0, num_checks = 0, cyc = 0;

    uvd_cmd_decoder #(.POLL_CYCLES(20), .HRST_CYCLES(8), .DESIG_DEFAULT(8'h24)) uvd_cmd_decoder_inst (
        .clk(clk), .sys_rst(sys_rst), .chip_rst_n(chip_rst_n), .bus_power_valid_in(bus_power_valid_in),
        .hs_handshake_ok(hs_handshake_ok), .dplus_pullup_en(dplus_pullup_en), .usb_high_speed(usb_high_speed),
        .usb_enable(usb_enable), .ata_active(ata_active), .mode_normal(mode_normal),
        .mode_board_test(mode_board_test), .cfg_rd_req(cfg_rd_req), .cfg_rd_addr(cfg_rd_addr),
        .cfg_rd_done(cfg_rd_done), .cfg_rd_nak(cfg_rd_nak), .cfg_rd_data(cfg_rd_data), .cbw_valid(cbw_valid),
        .cbw_first(cbw_first), .cbw_byte(cbw_byte), .data_valid(data_valid), .data_byte(data_byte),
        .cmd_cfg_load(cmd_cfg_load), .cmd_cfg_read(cmd_cfg_read), .cmd_pass(cmd_pass), .cmd_fail(cmd_fail),
        .cmd_ok(cmd_ok), .xfer_len(xfer_len), .rd_valid(rd_valid), .rd_byte(rd_byte),
        .pin_test_mode(pin_test_mode), .func_reg_sel(func_reg_sel), .func_cs_n(func_cs_n),
        .func_drive_reset_n(func_drive_reset_n), .func_wr_n(func_wr_n), .func_rd_n(func_rd_n),
        .func_dmack_n(func_dmack_n), .func_data_out(func_data_out), .func_data_oe(func_data_oe),
        .intrq_in(intrq_in), .iordy_in(iordy_in), .dmarq_in(dmarq_in), .ata_en_in(ata_en_in),
        .ata_data_lines_in(ata_data_lines_in), .ata_reg_select(ata_reg_select), .ata_cs_n(ata_cs_n),
        .drive_reset_n(drive_reset_n), .ata_write_strobe_n(ata_write_strobe_n),
        .ata_read_strobe_n(ata_read_strobe_n), .ata_dma_ack_n(ata_dma_ack_n),
        .ata_data_lines_out(ata_data_lines_out), .ata_data_lines_oe(ata_data_lines_oe));
    uvd_mem_model #(.DESIG(DESIG)) uvd_mem_model_inst (.clk(clk), .sys_rst(sys_rst), .mem_mode(mem_mode),
        .mem_dly(mem_dly), .cfg_rd_req(cfg_rd_req), .cfg_rd_addr(cfg_rd_addr), .cfg_rd_done(cfg_rd_done),
        .cfg_rd_nak(cfg_rd_nak), .cfg_rd_data(cfg_rd_data));

    always #50 clk = ~clk;
    always @(posedge clk) begin
        mask_ff <= clr ? 5'h00 : mask_ff | {cmd_ok, cmd_fail, cmd_pass, cmd_cfg_read, cmd_cfg_load};
        if (rd_valid === 1'b1) begin
            rdq.push_back(rd_byte);
        end
        cyc <= cyc + 1;
        if (cyc == 12000) begin
            err_count++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [4:0] exp_mask(input logic [7:0] d, input logic [31:0] len, input logic dir);
        logic z;
        z = 1'b1;
        for (int i = 2; i < 16; i++) z = z & (cb[i] == 8'h00);
        if (cb[0] != d) return 5'h04;
        if (cb[1] == 8'h26 && cb[2] == 8'h00 && cb[3] == 8'h02 && {cb[5], cb[4]} == 16'h0000 &&
            len <= 32'h0000_00FF) return dir ? 5'h02 : 5'h01;
        // Pin load shows nothing before its data
        if (cb[1] == 8'h27 && z) return dir ? 5'h10 : 5'h00;
        return 5'h08;
    endfunction
    function automatic logic [7:0] wbyte(input int i, input logic [31:0] len, input logic dir);
        if (i >= 15) return cb[i - 15];
        case (i)
            8: return len[7:0];
            9: return len[15:8];
            10: return len[23:16];
            11: return len[31:24];
            12: return {dir, 7'h00};
            13: return 8'h00;
            14: return 8'h10;
            default: return 8'h3C;
        endcase
    endfunction
    function automatic logic [7:0] snap(input int k);
        case (k)
            0: return {func_drive_reset_n, bus_power_valid_in, 5'h00, intrq_in};
            1: return {func_data_oe, 1'b0, ata_en_in, dmarq_in, iordy_in, 3'h0};
            2: return ata_data_lines_in[7:0];
            3: return ata_data_lines_in[15:8];
            default: return 8'h00;
        endcase
    endfunction
    task automatic set_cb(input logic [7:0] d, input logic [7:0] sub);
        for (int i = 0; i < 16; i++) cb[i] = 8'h00;
        cb[0] = d;
        cb[1] = sub;
        cb[3] = (sub == 8'h26) ? 8'h02 : 8'h00;
    endtask
    task automatic run_cmd(input logic [31:0] len, input logic dir, input logic [7:0] d);
        logic [4:0] em;
        em = exp_mask(d, len, dir);
        rdq.delete();
        for (int i = 0; i < 31; i++) begin
            @(negedge clk);
            clr = (i == 0);
            cbw_valid = 1'b1;
            cbw_first = (i == 0);
            cbw_byte = wbyte(i, len, dir);
        end
        @(negedge clk);
        cbw_valid = 1'b0;
        repeat (12) @(negedge clk);
        chk_val(mask_ff, em);
        chk_val(xfer_len, len);
        if (em == 5'h10) begin
            chk_val(32'(rdq.size()), 32'h0000_0008);
            for (int k = 0; k < 8 && k < rdq.size(); k++) chk_val(rdq[k], snap(k));
        end
    endtask
    task automatic rnd_func();
        {func_reg_sel, func_cs_n, func_drive_reset_n, func_wr_n, func_rd_n, func_dmack_n, func_data_oe} =
            10'($urandom);
        func_data_out = 16'($urandom);
        {intrq_in, iordy_in, dmarq_in, ata_en_in} = 4'($urandom);
        ata_data_lines_in = 16'($urandom);
    endtask
    task automatic boot(input logic [1:0] m, input logic [3:0] dl);
        mem_mode = m;
        mem_dly = dl;
        hs_handshake_ok = 1'($urandom);
        sys_rst = 1'b1;
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        for (int i = 0; i < 200 && mode_normal !== 1'b1 && mode_board_test !== 1'b1; i++) @(negedge clk);
        chk_val(mode_normal, m == 2'h0);
        chk_val(mode_board_test, m != 2'h0);
        chk_val({usb_enable, ata_active}, {1'b1, m == 2'h0});
        chk_val(usb_high_speed, hs_handshake_ok);
        // Designator stays at default without a full boot read
        set_cb(8'h24, 8'h26);
        run_cmd(32'h0000_0010, 1'b1, (m == 2'h0) ? DESIG : 8'h24);
    endtask
    task automatic chk_pins();
        chk_val({ata_reg_select, ata_cs_n, drive_reset_n, ata_write_strobe_n, ata_read_strobe_n, ata_dma_ack_n,
                 ata_data_lines_oe, ata_data_lines_out}, {pin[0][3:1], pin[0][5:4], pin[0][7], pin[1][0],
                 pin[1][1], pin[1][2], pin[1][7], pin[3], pin[2]});
        chk_val({pin_test_mode, ata_active}, 2'h2);
    endtask

    initial begin
        void'($urandom(32'hfbbe));
        {sys_rst, chip_rst_n, bus_power_valid_in, hs_handshake_ok, ata_en_in} = 5'h1F;
        {clr, cbw_valid, cbw_first, data_valid, cbw_byte, data_byte} = 20'h0_0000;
        rnd_func();
        boot(2'h1, 4'h1);
        boot(2'h2, 4'h6);
        boot(2'h0, 4'h6);
        bus_power_valid_in = 1'b0;
        repeat (30) @(negedge clk);
        chk_val(dplus_pullup_en, 32'h0000_0000);
        bus_power_valid_in = 1'b1;
        repeat (30) @(negedge clk);
        chk_val(dplus_pullup_en, 32'h0000_0001);
        for (int k = 0; k < 3; k++) begin
            set_cb(DESIG, 8'h26);
            if (k == 2) cb[3] = 8'h01;
            run_cmd((k == 1) ? 32'h0000_0100 : 32'h0000_00FF, k != 0, DESIG);
        end
        set_cb(DESIG, 8'h27);
        run_cmd(32'h0000_0008, 1'b1, DESIG);
        for (int n = 0; n < 24; n++) begin
            case ($urandom_range(3))
                0: set_cb(DESIG, 8'h26);
                1: set_cb(DESIG, 8'h27);
                2: set_cb(DESIG, 8'h25);
                default: set_cb(DESIG, 8'($urandom));
            endcase
            if ($urandom_range(3) == 0) cb[0] = 8'h11;
            if ($urandom_range(2) == 0) cb[$urandom_range(15, 2)] = 8'($urandom_range(255, 1));
            rnd_func();
            // Pin loads kept out: they end normal control
            run_cmd(32'($urandom_range(300)), (cb[1] == 8'h27) || ($urandom_range(1) == 1), DESIG);
        end
        // Pin load with exactly seven bytes
        set_cb(DESIG, 8'h27);
        run_cmd(32'h0000_0007, 1'b0, DESIG);
        for (int i = 0; i < 7; i++) begin
            @(negedge clk);
            pin[i] = 8'($urandom);
            data_valid = 1'b1;
            data_byte = pin[i];
        end
        @(negedge clk);
        data_valid = 1'b0;
        repeat (4) @(negedge clk);
        chk_val(mask_ff, 5'h10);
        chk_pins();
        rnd_func();
        set_cb(DESIG, 8'h26);
        run_cmd(32'h0000_0020, 1'b1, DESIG);
        chk_pins();
        // Short reset pulse is ignored, long one clears
        chip_rst_n = 1'b0;
        repeat (3) @(negedge clk);
        chip_rst_n = 1'b1;
        repeat (4) @(negedge clk);
        chk_val(pin_test_mode, 32'h0000_0001);
        chip_rst_n = 1'b0;
        repeat (14) @(negedge clk);
        chip_rst_n = 1'b1;
        repeat (4) @(negedge clk);
        chk_val(pin_test_mode, 32'h0000_0000);
        end_sim();
    end
endmodule

// >>> testbench/uvd_mem_model.sv
// Configuration memory model answering the power-up reads
`timescale 1ns/100ps
module uvd_mem_model #(
    parameter logic [7:0] DESIG = 8'h5A
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [1:0] mem_mode,
    input wire logic [3:0] mem_dly,
    input wire logic cfg_rd_req,
    input wire logic [7:0] cfg_rd_addr,
    output logic cfg_rd_done,
    output logic cfg_rd_nak,
    output logic [7:0] cfg_rd_data
);
    logic [3:0] cnt_ff;
    logic [7:0] word;
    logic idle;
    // Signature pair, mode 1 spoils one
    assign word = (cfg_rd_addr == 8'h00) ? 8'h4D :
                  (cfg_rd_addr == 8'h01) ? ((mem_mode == 2'h1) ? 8'h4C : 8'h4D) :
                  (cfg_rd_addr == 8'h04) ? DESIG : 8'hA5;
    assign idle = sys_rst | ~cfg_rd_req | cfg_rd_done | cfg_rd_nak;
    always @(posedge clk) begin
        cfg_rd_done <= 1'b0;
        cfg_rd_nak <= 1'b0;
        // Data line keeps toggling when not answering
        cfg_rd_data <= sys_rst ? 8'h00 : ~cfg_rd_data;
        if (idle) begin
            cnt_ff <= 4'h0;
        end else if (cnt_ff == mem_dly) begin
            // Mode 2 stands for a missing memory
            cfg_rd_done <= (mem_mode != 2'h2);
            cfg_rd_nak <= (mem_mode == 2'h2);
            cfg_rd_data <= word;
        end else begin
            cnt_ff <= cnt_ff + 4'h1;
        end
    end
endmodule
